// ### verilog/lfl_fault_latch.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ns
module lfl_fault_latch
  import lfl_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       disablePin,
  input  wire logic       biasMonOverPin,
  input  wire logic [7:0] pdCurrent,
  input  wire logic [7:0] biasDacValue,
  input  wire logic       biasDacUpdate,
  output logic      [7:0] biasCurrentCode,
  output logic      [7:0] modCurrentCode,
  output logic            currentsOn,
  output logic            faultFlagOut,
  output logic            irq
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Only the second stage is ever read by logic.
  logic [1:0] disSync_reg;
  logic [1:0] disSync_next;
  logic [1:0] monSync_reg;
  logic [1:0] monSync_next;

  always_comb begin
    disSync_next = {disSync_reg[0], disablePin};
    monSync_next = {monSync_reg[0], biasMonOverPin};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      disSync_reg <= 2'b11;
      monSync_reg <= 2'b00;
    end else begin
      disSync_reg <= disSync_next;
      monSync_reg <= monSync_next;
    end
  end

  logic disPinHigh;
  logic monOver;
  assign disPinHigh = disSync_reg[1];
  assign monOver    = monSync_reg[1];

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] modSet_reg;
  logic [7:0] modSet_next;
  logic [7:0] biasSet_reg;
  logic [7:0] biasSet_next;
  logic [7:0] pdTarget_reg;
  logic [7:0] pdTarget_next;
  logic [2:0] irqMask_reg;
  logic [2:0] irqMask_next;

  // Disabling never touches these; only software writes change them.
  always_comb begin
    ctrl_next     = ctrl_reg;
    modSet_next   = modSet_reg;
    biasSet_next  = biasSet_reg;
    pdTarget_next = pdTarget_reg;
    irqMask_next  = irqMask_reg;
    if (regWr) begin
      unique case (regAddr)
        ADDR_CTRL:     ctrl_next     = regWrData;
        ADDR_MOD:      modSet_next   = regWrData;
        ADDR_BIAS:     biasSet_next  = regWrData;
        ADDR_PDTGT:    pdTarget_next = regWrData;
        ADDR_IRQ_MASK: irqMask_next  = regWrData[2:0];
        default:       ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg     <= CTRL_RESET;
      modSet_reg   <= MOD_RESET;
      biasSet_reg  <= BIAS_RESET;
      pdTarget_reg <= PDTGT_RESET;
      irqMask_reg  <= IRQ_RESET;
    end else begin
      ctrl_reg     <= ctrl_next;
      modSet_reg   <= modSet_next;
      biasSet_reg  <= biasSet_next;
      pdTarget_reg <= pdTarget_next;
      irqMask_reg  <= irqMask_next;
    end
  end

  logic chipEnable;
  logic faultDetectEnable;
  logic disabled;
  assign chipEnable        = ctrl_reg[CTRL_ENABLE_BIT];
  assign faultDetectEnable = ctrl_reg[CTRL_FAULT_DETECT_ENABLE_BIT];
  assign disabled          = disPinHigh | ~chipEnable;

  // ---------------------------------------------------------------------------
  // Fault conditions
  // ---------------------------------------------------------------------------
  logic [7:0]  prevDac_reg;
  logic [7:0]  prevDac_next;
  logic [9:0]  pdScaled;
  logic [11:0] tgtScaled;
  logic        pdOver;
  logic [7:0]  dacDelta;
  logic [14:0] deltaScaled;
  logic [14:0] prevScaled;
  logic        dacDrop;
  logic        condAny;
  logic        trigger;

  always_comb begin
    prevDac_next = biasDacUpdate ? biasDacValue : prevDac_reg;
    pdScaled     = {2'b00, pdCurrent} * 10'(PD_OVER_DEN);
    tgtScaled    = {4'h0, pdTarget_reg} * 12'(PD_OVER_NUM);
    pdOver       = {2'b00, pdScaled} > tgtScaled;
    dacDelta     = prevDac_reg - biasDacValue;
    deltaScaled  = {7'h00, dacDelta} * {7'h00, FULL_PERCENT};
    prevScaled   = {7'h00, prevDac_reg} * {7'h00, DROP_PERCENT};
    // The drop is judged against the value before the step.
    dacDrop      = biasDacUpdate && (biasDacValue < prevDac_reg)
                   && (deltaScaled > prevScaled);
    condAny      = monOver | pdOver | dacDrop;
    trigger      = faultDetectEnable & condAny;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prevDac_reg <= 8'h00;
    end else begin
      prevDac_reg <= prevDac_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Supervisor state machine
  // ---------------------------------------------------------------------------
  lfl_state_e  state_reg;
  lfl_state_e  state_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic        latch_reg;
  logic        latch_next;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    latch_next = latch_reg;
    unique case (state_reg)
      ST_OFF: begin
        // The latch only clears after a long enough disabling period.
        if (disabled) begin
          if (cnt_reg != RESET_CYC) begin
            cnt_next = cnt_reg + 12'h001;
          end
          if (cnt_reg == RESET_CYC - 12'h001) begin
            latch_next = 1'b0;
          end
        end else if (latch_reg || trigger) begin
          state_next = ST_FAULT;
          latch_next = 1'b1;
          cnt_next   = 12'h000;
        end else begin
          state_next = ST_WAKE;
          cnt_next   = 12'h000;
        end
      end
      ST_WAKE: begin
        if (disabled) begin
          state_next = ST_OFF;
          cnt_next   = 12'h000;
        end else if (trigger) begin
          state_next = ST_FAULT;
          latch_next = 1'b1;
        end else if (cnt_reg == TON_CYC - 12'h001) begin
          state_next = ST_RUN;
          cnt_next   = 12'h000;
        end else begin
          cnt_next = cnt_reg + 12'h001;
        end
      end
      ST_RUN: begin
        if (disabled) begin
          state_next = ST_OFF;
          cnt_next   = 12'h000;
        end else if (trigger) begin
          state_next = ST_FAULT;
          latch_next = 1'b1;
        end
      end
      ST_FAULT: begin
        if (disabled) begin
          state_next = ST_OFF;
          cnt_next   = 12'h000;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
      cnt_reg   <= 12'h000;
      latch_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      latch_reg <= latch_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Drive outputs
  // ---------------------------------------------------------------------------
  logic [7:0] biasOut_reg;
  logic [7:0] biasOut_next;
  logic [7:0] modOut_reg;
  logic [7:0] modOut_next;
  logic       on_reg;
  logic       on_next;
  logic       flag_reg;
  logic       flag_next;

  // Outputs follow the next state so they line up with state_reg.
  always_comb begin
    on_next      = (state_next == ST_RUN);
    biasOut_next = on_next ? biasSet_reg : 8'h00;
    modOut_next  = on_next ? modSet_reg : 8'h00;
    flag_next    = (state_next == ST_FAULT) && ctrl_next[CTRL_FAULT_DETECT_ENABLE_BIT];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      biasOut_reg <= 8'h00;
      modOut_reg  <= 8'h00;
      on_reg      <= 1'b0;
      flag_reg    <= 1'b0;
    end else begin
      biasOut_reg <= biasOut_next;
      modOut_reg  <= modOut_next;
      on_reg      <= on_next;
      flag_reg    <= flag_next;
    end
  end

  assign biasCurrentCode = biasOut_reg;
  assign modCurrentCode  = modOut_reg;
  assign currentsOn      = on_reg;
  assign faultFlagOut    = flag_reg;

  // ---------------------------------------------------------------------------
  // Interrupts and read port
  // ---------------------------------------------------------------------------
  logic [2:0] irqStat_reg;
  logic [2:0] irqStat_next;
  logic [2:0] irqEvent;
  logic       irq_reg;
  logic       irq_next;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;

  // A set in the same cycle as a write-one clear wins.
  always_comb begin
    irqEvent[IRQ_FAULT_BIT]   = (state_next == ST_FAULT) && (state_reg != ST_FAULT);
    irqEvent[IRQ_RESUME_BIT]  = (state_next == ST_RUN) && (state_reg != ST_RUN);
    irqEvent[IRQ_DACDROP_BIT] = dacDrop;
    irqStat_next = irqStat_reg;
    if (regWr && regAddr == ADDR_IRQ_STAT) begin
      irqStat_next = irqStat_reg & ~regWrData[2:0];
    end
    irqStat_next = irqStat_next | irqEvent;
    irq_next     = |(irqStat_next & irqMask_next);
    rdData_next  = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL:     rdData_next = ctrl_reg;
        ADDR_MOD:      rdData_next = modSet_reg;
        ADDR_BIAS:     rdData_next = biasSet_reg;
        ADDR_PDTGT:    rdData_next = pdTarget_reg;
        ADDR_STATUS:   rdData_next = {1'b0, state_reg, latch_reg, disPinHigh, pdOver, monOver, flag_reg};
        ADDR_IRQ_STAT: rdData_next = {5'h00, irqStat_reg};
        ADDR_IRQ_MASK: rdData_next = {5'h00, irqMask_reg};
        default:       rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_reg <= IRQ_RESET;
      irq_reg     <= 1'b0;
      rdData_reg  <= 8'h00;
    end else begin
      irqStat_reg <= irqStat_next;
      irq_reg     <= irq_next;
      rdData_reg  <= rdData_next;
    end
  end

  assign irq       = irq_reg;
  assign regRdData = rdData_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  mon_over_trip_a: assert property (
    (monOver && faultDetectEnable && !disabled && state_reg == ST_RUN && !regWr) |=> faultFlagOut && !currentsOn)
    else $error("Bias monitor over-voltage did not trip the fault.");

  pd_over_trip_a: assert property (
    (pdOver && faultDetectEnable && !disabled && (state_reg == ST_WAKE || state_reg == ST_RUN)) |=> state_reg == ST_FAULT)
    else $error("Photodiode over-current did not trip the fault.");

  dac_drop_trip_a: assert property (
    (dacDrop && faultDetectEnable && !disabled && state_reg == ST_RUN) |=> latch_reg)
    else $error("Bias DAC drop did not latch the fault.");

  fault_zero_a: assert property (
    state_reg == ST_FAULT |-> biasCurrentCode == 8'h00 && modCurrentCode == 8'h00)
    else $error("Currents not zero during a fault.");

  flag_held_a: assert property (
    (faultFlagOut && !disabled && faultDetectEnable && !(regWr && regAddr == ADDR_CTRL)) |=> faultFlagOut)
    else $error("Fault flag dropped without recovery.");

  flag_off_disabled_a: assert property (
    disabled |=> !faultFlagOut)
    else $error("Fault flag high while disabled.");

  resume_after_wake_a: assert property (
    (state_reg == ST_WAKE && cnt_reg == TON_CYC - 12'h001 && !disabled && !trigger) |=>
      currentsOn && biasCurrentCode == $past(biasSet_reg) && modCurrentCode == $past(modSet_reg))
    else $error("Did not resume prior settings after the negate time.");

  reassert_now_a: assert property (
    (state_reg == ST_OFF && !disabled && latch_reg && faultDetectEnable && !(regWr && regAddr == ADDR_CTRL))
      |=> faultFlagOut && !currentsOn)
    else $error("Fault flag not reasserted at re-enable.");

  pin_kills_current_a: assert property (
    disPinHigh |=> biasCurrentCode == 8'h00 && modCurrentCode == 8'h00 && !currentsOn)
    else $error("Currents on while disable pin high.");

  latch_hold_time_a: assert property (
    $fell(latch_reg) |-> $past(cnt_reg) == RESET_CYC - 12'h001 && $past(disabled))
    else $error("Fault latch cleared before the reset time.");

  detect_off_a: assert property (
    (!faultDetectEnable && !(regWr && regAddr == ADDR_CTRL)) |=> !faultFlagOut)
    else $error("Fault flag high with detection off.");

endmodule

// ### verilog/lfl_pkg.sv
package lfl_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL     = 3'h0;
  localparam logic [2:0] ADDR_MOD      = 3'h1;
  localparam logic [2:0] ADDR_BIAS     = 3'h2;
  localparam logic [2:0] ADDR_PDTGT    = 3'h3;
  localparam logic [2:0] ADDR_STATUS   = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h6;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FAULT_DETECT_ENABLE_BIT  = 1;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MOD_RESET  = 8'h00;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] PDTGT_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET  = 3'h0;

  localparam int IRQ_FAULT_BIT   = 0;
  localparam int IRQ_RESUME_BIT  = 1;
  localparam int IRQ_DACDROP_BIT = 2;

  // ---------------------------------------------------------------------------
  // Detection thresholds
  // ---------------------------------------------------------------------------
  localparam logic [3:0] PD_OVER_NUM  = 4'h3;
  localparam logic [3:0] PD_OVER_DEN  = 4'h2;
  localparam logic [7:0] DROP_PERCENT = 8'h21;
  localparam logic [7:0] FULL_PERCENT = 8'h64;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int T_RESET_NS      = 10000;
  localparam int T_ON_NS         = 1000;
  localparam int RESET_CYC_INT   = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TON_CYC_INT     = (T_ON_NS / CLK_PERIOD_NS < 1) ? 1 : T_ON_NS / CLK_PERIOD_NS;
  localparam logic [11:0] RESET_CYC = 12'(RESET_CYC_INT);
  localparam logic [11:0] TON_CYC   = 12'(TON_CYC_INT);

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_WAKE  = 2'b01,
    ST_RUN   = 2'b10,
    ST_FAULT = 2'b11
  } lfl_state_e;

endpackage

// ### dv/lfl_laser_model.sv
`timescale 1ns/1ns
module lfl_laser_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] biasCurrentCode,
  input  wire logic       currentsOn,
  input  wire logic       monOverForce,
  input  wire logic [7:0] pdExtra,
  output logic            biasMonOverPin,
  output logic      [7:0] pdCurrent
);
  // ---------------------------------------------------------------------------
  // Laser and monitor photodiode
  // ---------------------------------------------------------------------------
  // The photodiode sees the laser one clock late, plus stray light that the bench
  // sets, so an over-current can outlive the currents being switched off.
  always_ff @(posedge core_clk) begin
    pdCurrent      <= (currentsOn ? biasCurrentCode : 8'h00) + pdExtra;
    biasMonOverPin <= monOverForce;
  end
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench
  import lfl_pkg::*;
;
  logic       core_clk;
  logic       resetn;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdData;
  logic       disablePin;
  logic       biasMonOverPin;
  logic [7:0] pdCurrent;
  logic [7:0] biasDacValue;
  logic       biasDacUpdate;
  logic [7:0] biasCurrentCode;
  logic [7:0] modCurrentCode;
  logic       currentsOn;
  logic       faultFlagOut;
  logic       irq;
  logic       monOverForce;
  logic [7:0] pdExtra;
  logic [7:0] d;
  int         fails;
  int         checks_done;

  lfl_fault_latch uut (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .disablePin(disablePin),
    .biasMonOverPin(biasMonOverPin), .pdCurrent(pdCurrent), .biasDacValue(biasDacValue),
    .biasDacUpdate(biasDacUpdate), .biasCurrentCode(biasCurrentCode), .modCurrentCode(modCurrentCode),
    .currentsOn(currentsOn), .faultFlagOut(faultFlagOut), .irq(irq));

  lfl_laser_model model (.core_clk(core_clk), .biasCurrentCode(biasCurrentCode), .currentsOn(currentsOn),
    .monOverForce(monOverForce), .pdExtra(pdExtra), .biasMonOverPin(biasMonOverPin), .pdCurrent(pdCurrent));

  always #4 core_clk = ~core_clk;

  // ---------------------------------------------------------------------------
  // Access and checking tasks
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic chkOut(input logic f, input logic on, input logic [7:0] b, input logic [7:0] m, input string msg);
    chk({7'h00, faultFlagOut}, {7'h00, f}, msg);
    chk({7'h00, currentsOn}, {7'h00, on}, msg);
    chk(biasCurrentCode, b, msg);
    chk(modCurrentCode, m, msg);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wrReg(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rdReg(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
  endtask

  task automatic dacStep(input logic [7:0] v);
    @(posedge core_clk);
    biasDacValue  <= v;
    biasDacUpdate <= 1'b1;
    @(posedge core_clk);
    biasDacUpdate <= 1'b0;
  endtask

  // The host holds the disabling state past the latch reset time before re-enabling.
  task automatic recoverByEnable();
    wrReg(ADDR_CTRL, 8'h02);
    waitCyc(2);
    chkOut(1'b0, 1'b0, 8'h00, 8'h00, "enable bit cleared");
    waitCyc(RESET_CYC_INT + 4);
    wrReg(ADDR_CTRL, 8'h03);
    waitCyc(TON_CYC_INT + 6);
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    disablePin = 1'b0;
    biasDacValue = 8'h00;
    biasDacUpdate = 1'b0;
    monOverForce = 1'b0;
    pdExtra = 8'h00;
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    waitCyc(1);
    chkOut(1'b0, 1'b0, 8'h00, 8'h00, "after reset");
    for (int i = 0; i < 8; i++) begin
      rdReg(i[2:0], d);
      chk(d, 8'h00, "reset value");
    end
    wrReg(ADDR_BIAS, 8'h40);
    wrReg(ADDR_MOD, 8'h30);
    wrReg(ADDR_PDTGT, 8'h40);
    wrReg(ADDR_IRQ_MASK, 8'h07);
    wrReg(ADDR_CTRL, 8'h03);
    waitCyc(TON_CYC_INT + 6);
    chkOut(1'b0, 1'b1, 8'h40, 8'h30, "first run");
    monOverForce <= 1'b1;
    waitCyc(5);
    chkOut(1'b1, 1'b0, 8'h00, 8'h00, "monitor over");
    chk({7'h00, irq}, 8'h01, "fault irq");
    monOverForce <= 1'b0;
    waitCyc(6);
    chkOut(1'b1, 1'b0, 8'h00, 8'h00, "latched");
    wrReg(ADDR_IRQ_STAT, 8'h07);
    waitCyc(2);
    chk({7'h00, irq}, 8'h00, "irq cleared");
    recoverByEnable();
    chkOut(1'b0, 1'b1, 8'h40, 8'h30, "resume");
    rdReg(ADDR_BIAS, d);
    chk(d, 8'h40, "setting kept");
    pdExtra <= 8'h20;
    waitCyc(5);
    chk({7'h00, faultFlagOut}, 8'h00, "pd at limit");
    pdExtra <= 8'h70;
    waitCyc(4);
    chkOut(1'b1, 1'b0, 8'h00, 8'h00, "pd over");
    rdReg(ADDR_STATUS, d);
    chk(d, 8'h75, "status in fault");
    disablePin <= 1'b1;
    waitCyc(4);
    chkOut(1'b0, 1'b0, 8'h00, 8'h00, "pin disable");
    waitCyc(RESET_CYC_INT + 4);
    disablePin <= 1'b0;
    waitCyc(4);
    chkOut(1'b1, 1'b0, 8'h00, 8'h00, "fault persists");
    pdExtra <= 8'h00;
    disablePin <= 1'b1;
    waitCyc(RESET_CYC_INT + 6);
    disablePin <= 1'b0;
    waitCyc(TON_CYC_INT + 8);
    chkOut(1'b0, 1'b1, 8'h40, 8'h30, "pin resume");
    wrReg(ADDR_IRQ_MASK, 8'h00);
    wrReg(ADDR_IRQ_STAT, 8'h07);
    dacStep(8'h64);
    dacStep(8'h43);
    waitCyc(3);
    chk({7'h00, faultFlagOut}, 8'h00, "drop of 33");
    dacStep(8'h64);
    dacStep(8'h42);
    waitCyc(3);
    chkOut(1'b1, 1'b0, 8'h00, 8'h00, "drop of 34");
    chk({7'h00, irq}, 8'h00, "masked irq");
    rdReg(ADDR_IRQ_STAT, d);
    chk(d & 8'h05, 8'h05, "drop events");
    wrReg(ADDR_IRQ_MASK, 8'h07);
    waitCyc(2);
    chk({7'h00, irq}, 8'h01, "unmasked irq");
    wrReg(ADDR_IRQ_STAT, 8'h07);
    waitCyc(2);
    chk({7'h00, irq}, 8'h00, "irq cleared again");
    // A disabling period shorter than the latch reset time must not clear the fault.
    wrReg(ADDR_CTRL, 8'h02);
    waitCyc(3);
    chkOut(1'b0, 1'b0, 8'h00, 8'h00, "short disable");
    wrReg(ADDR_CTRL, 8'h03);
    waitCyc(3);
    chkOut(1'b1, 1'b0, 8'h00, 8'h00, "short disable refault");
    recoverByEnable();
    wrReg(ADDR_CTRL, 8'h01);
    monOverForce <= 1'b1;
    pdExtra <= 8'h70;
    waitCyc(6);
    chkOut(1'b0, 1'b1, 8'h40, 8'h30, "detection off");
    end_sim();
  end

  initial begin
    repeat (6 * RESET_CYC_INT + 10 * TON_CYC_INT + 2000) @(posedge core_clk);
    fails++;
    end_sim();
  end
endmodule
